// file: src/fh_cfg.svh
// constants of the parallel nor flash host controller
`ifndef FH_CFG_SVH
`define FH_CFG_SVH
// clock period and least bus times
`define FH_CLK_NS 5
`define FH_CEIL(t) (((t) + `FH_CLK_NS - 1) / `FH_CLK_NS)
`define FH_T_AS_NS 10
`define FH_T_WP_NS 35
`define FH_T_WPH_NS 20
`define FH_T_ACC_NS 110
`define FH_T_BUSY_NS 90
`define FH_T_RP_NS 500
`define FH_T_RH_NS 50
`define FH_AS_CYC `FH_CEIL(`FH_T_AS_NS)
`define FH_WP_CYC `FH_CEIL(`FH_T_WP_NS)
`define FH_WPH_CYC `FH_CEIL(`FH_T_WPH_NS)
`define FH_ACC_CYC `FH_CEIL(`FH_T_ACC_NS)
`define FH_BUSY_CYC `FH_CEIL(`FH_T_BUSY_NS)
`define FH_RP_CYC `FH_CEIL(`FH_T_RP_NS)
`define FH_RH_CYC `FH_CEIL(`FH_T_RH_NS)
// register byte offsets
`define FH_REG_CTRL 8'h00
`define FH_REG_ADDR 8'h04
`define FH_REG_WDATA 8'h08
`define FH_REG_STAT 8'h0C
`define FH_REG_INT 8'h10
`define FH_REG_MASK 8'h14
`define FH_REG_RDATA 8'h18
`define FH_REG_CFG 8'h1C
// field positions
`define FH_CTRL_GO 4
`define FH_CFG_BYTE 0
`define FH_CFG_WP 1
`define FH_CFG_POLL 2
`define FH_INT_DONE 0
`define FH_INT_TMO 1
`define FH_INT_REF 2
`define FH_POL_BIT 7
`define FH_TOG_BIT 6
// reset values
`define FH_CFG_RST 4'h2
`define FH_MASK_RST 3'h0
// command codes and unlock addresses
`define FH_CMD_UNL1 8'hAA
`define FH_CMD_UNL2 8'h55
`define FH_CMD_PROG 8'hA0
`define FH_CMD_ERASE 8'h80
`define FH_CMD_SECT 8'h30
`define FH_CMD_CHIP 8'h10
`define FH_CMD_BYP 8'h20
`define FH_CMD_BYPX1 8'h90
`define FH_CMD_BYPX2 8'h00
`define FH_CMD_ESUS 8'hB0
`define FH_CMD_ERES 8'h30
`define FH_CMD_PSUS 8'h51
`define FH_CMD_PRES 8'h50
`define FH_CMD_RST 8'hF0
`define FH_UNL1_W 26'h0555
`define FH_UNL2_W 26'h02AA
`define FH_UNL1_B 26'h0AAA
`define FH_UNL2_B 26'h0555
`endif

// file: src/fh_pkg.sv
// types of the parallel nor flash host controller
package fh_pkg;
  typedef enum logic [3:0] {
    OP_READ = 4'b0000, OP_PROG = 4'b0001, OP_SERS = 4'b0010, OP_CERS = 4'b0011,
    OP_BYPE = 4'b0100, OP_BYPP = 4'b0101, OP_BYPX = 4'b0110, OP_ESUS = 4'b0111,
    OP_ERES = 4'b1000, OP_PSUS = 4'b1001, OP_PRES = 4'b1010, OP_RSTC = 4'b1011,
    OP_HWRS = 4'b1100
  } fh_op_t;
  typedef enum logic [1:0] {SA_U1 = 2'b00, SA_U2 = 2'b01, SA_USR = 2'b10} fh_asel_t;
  typedef enum logic [3:0] {
    S_IDLE = 4'b0000, S_ISSUE = 4'b0001, S_WAITC = 4'b0010, S_SETTLE = 4'b0011,
    S_POLL = 4'b0100, S_POLLW = 4'b0101, S_HWRST = 4'b0110, S_RECOV = 4'b0111
  } fh_st_t;
  typedef enum logic [1:0] {C_IDLE = 2'b00, C_SETUP = 2'b01, C_PULSE = 2'b10,
    C_HOLD = 2'b11} fh_cst_t;
endpackage : fh_pkg

// file: src/fh_cyc.sv
// one asynchronous flash bus cycle, write or read
`timescale 1ns/1ps
`include "fh_cfg.svh"
module fh_cyc
  import fh_pkg::*;
#(
  parameter int AW = 26
)(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic start,
  input wire logic wr,
  input wire logic [AW-1:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic [15:0] fl_dq_i,
  output logic [AW-1:0] fl_addr,
  output logic [15:0] fl_dq_o,
  output logic fl_dq_oe_n,
  output logic fl_ce_n,
  output logic fl_we_n,
  output logic fl_oe_n,
  output logic [15:0] rd_data,
  output logic done
);
  fh_cst_t st_q;
  logic wr_q;
  logic [7:0] cnt_q;
  logic [15:0] dq_m_q;
  logic [15:0] dq_s_q;

  // pin data passes two flops before use
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      dq_m_q <= 16'h0000;
      dq_s_q <= 16'h0000;
    end
    else
    begin
      dq_m_q <= fl_dq_i;
      dq_s_q <= dq_m_q;
    end
  end

  // strobe sequencing; ce frames the whole cycle, we and oe never overlap
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      st_q <= C_IDLE;
      wr_q <= 1'b0;
      cnt_q <= 8'h00;
      fl_addr <= '0;
      fl_dq_o <= 16'h0000;
      fl_dq_oe_n <= 1'b1;
      fl_ce_n <= 1'b1;
      fl_we_n <= 1'b1;
      fl_oe_n <= 1'b1;
      rd_data <= 16'h0000;
      done <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      case (st_q)
        C_IDLE:
          if (start)
          begin
            wr_q <= wr;
            fl_addr <= addr_i;
            fl_dq_o <= wdata_i;
            fl_dq_oe_n <= ~wr;
            fl_ce_n <= 1'b0;
            cnt_q <= 8'(`FH_AS_CYC - 1);
            st_q <= C_SETUP;
          end
        C_SETUP:
          if (cnt_q == 8'h00)
          begin
            fl_we_n <= ~wr_q;
            fl_oe_n <= wr_q;
            // read waits two extra cycles for the synchroniser
            cnt_q <= wr_q ? 8'(`FH_WP_CYC - 1) : 8'(`FH_ACC_CYC + 1);
            st_q <= C_PULSE;
          end
          else
            cnt_q <= cnt_q - 8'h01;
        C_PULSE:
          if (cnt_q == 8'h00)
          begin
            fl_we_n <= 1'b1;
            fl_oe_n <= 1'b1;
            if (!wr_q)
              rd_data <= dq_s_q;
            cnt_q <= 8'(`FH_WPH_CYC - 1);
            st_q <= C_HOLD;
          end
          else
            cnt_q <= cnt_q - 8'h01;
        default:
          if (cnt_q == 8'h00)
          begin
            fl_ce_n <= 1'b1;
            fl_dq_oe_n <= 1'b1;
            done <= 1'b1;
            st_q <= C_IDLE;
          end
          else
            cnt_q <= cnt_q - 8'h01;
      endcase
    end
  end
endmodule : fh_cyc

// file: src/fh_host.sv
// host controller driving an asynchronous parallel nor flash
//
// Local design decisions: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`include "fh_cfg.svh"
module fh_host
  import fh_pkg::*;
#(
  parameter int AW = 26,
  parameter int POLL_LIMIT = 400000000
)(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [31:0] reg_rdata,
  output logic irq,
  output logic [AW-1:0] fl_addr,
  input wire logic [15:0] fl_dq_i,
  output logic [15:0] fl_dq_o,
  output logic fl_dq_oe_n,
  output logic fl_ce_n,
  output logic fl_we_n,
  output logic fl_oe_n,
  output logic fl_byte_n,
  output logic fl_reset_n,
  output logic protect_accel_pin,
  input wire logic done_indicator
);
  fh_st_t st_q;
  fh_op_t op_q;
  logic [AW-1:0] addr_q;
  logic [15:0] wdata_q;
  logic [3:0] cfg_q;
  logic [2:0] mask_q;
  logic [2:0] int_q;
  logic [15:0] rdata_q;
  logic [2:0] idx_q;
  logic [31:0] tmo_q;
  logic [7:0] wcnt_q;
  logic tog_q;
  logic tog_v_q;
  logic tmo_err_q;
  logic byp_q;
  logic cyc_go_q;
  logic cyc_wr_q;
  logic ev_done_q;
  logic ev_tmo_q;
  logic ev_ref_q;
  logic rdy_m_q;
  logic rdy_s_q;
  logic [11:0] step;
  logic step_last;
  fh_asel_t step_as;
  logic [AW-1:0] cyc_addr;
  logic [15:0] cyc_wd;
  logic [15:0] cyc_rd;
  logic cyc_done;
  logic go_req;
  logic is_wait_op;
  logic pol_ok;

  // command table: {last, address select, use user data, code}
  function automatic logic [11:0] fh_step(input fh_op_t op, input logic [2:0] i);
    logic [11:0] s;
    s = (i == 3'd1 || i == 3'd4) ? {1'b0, SA_U2, 1'b0, `FH_CMD_UNL2} :
        {1'b0, SA_U1, 1'b0, `FH_CMD_UNL1};
    case (op)
      OP_PROG:
        if (i == 3'd2)
          s = {1'b0, SA_U1, 1'b0, `FH_CMD_PROG};
        else if (i == 3'd3)
          s = {1'b1, SA_USR, 1'b1, 8'h00};
      OP_SERS, OP_CERS:
        if (i == 3'd2)
          s = {1'b0, SA_U1, 1'b0, `FH_CMD_ERASE};
        else if (i == 3'd5)
          s = (op == OP_SERS) ? {1'b1, SA_USR, 1'b0, `FH_CMD_SECT} :
              {1'b1, SA_U1, 1'b0, `FH_CMD_CHIP};
      OP_BYPE:
        if (i == 3'd2)
          s = {1'b1, SA_U1, 1'b0, `FH_CMD_BYP};
      OP_BYPP:
        s = (i == 3'd0) ? {1'b0, SA_USR, 1'b0, `FH_CMD_PROG} : {1'b1, SA_USR, 1'b1, 8'h00};
      OP_BYPX:
        s = (i == 3'd0) ? {1'b0, SA_USR, 1'b0, `FH_CMD_BYPX1} :
            {1'b1, SA_USR, 1'b0, `FH_CMD_BYPX2};
      OP_ESUS:
        s = {1'b1, SA_USR, 1'b0, `FH_CMD_ESUS};
      OP_ERES:
        s = {1'b1, SA_USR, 1'b0, `FH_CMD_ERES};
      OP_PSUS:
        s = {1'b1, SA_USR, 1'b0, `FH_CMD_PSUS};
      OP_PRES:
        s = {1'b1, SA_USR, 1'b0, `FH_CMD_PRES};
      default:
        s = {1'b1, SA_USR, 1'b0, `FH_CMD_RST};
    endcase
    return s;
  endfunction : fh_step

  // current step decode; unlock addresses double in byte mode
  always_comb
  begin
    step = fh_step(op_q, idx_q);
    step_last = step[11];
    step_as = fh_asel_t'(step[10:9]);
    cyc_wd = step[8] ? wdata_q : {8'h00, step[7:0]};
    if (!cyc_wr_q || step_as == SA_USR)
      cyc_addr = addr_q;
    else if (step_as == SA_U1)
      cyc_addr = AW'(cfg_q[`FH_CFG_BYTE] ? `FH_UNL1_B : `FH_UNL1_W);
    else
      cyc_addr = AW'(cfg_q[`FH_CFG_BYTE] ? `FH_UNL2_B : `FH_UNL2_W);
  end

  // completion checks; erased data reads as ones
  always_comb
  begin
    go_req = reg_we && reg_addr == `FH_REG_CTRL && reg_wdata[`FH_CTRL_GO];
    is_wait_op = op_q == OP_PROG || op_q == OP_BYPP || op_q == OP_SERS || op_q == OP_CERS;
    if (op_q == OP_SERS || op_q == OP_CERS)
      pol_ok = cyc_rd[`FH_POL_BIT];
    else
      pol_ok = cyc_rd[`FH_POL_BIT] == wdata_q[`FH_POL_BIT];
  end

  fh_cyc #(
    .AW(AW)
  ) u_cyc (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .start(cyc_go_q),
    .wr(cyc_wr_q),
    .addr_i(cyc_addr),
    .wdata_i(cyc_wd),
    .fl_dq_i(fl_dq_i),
    .fl_addr(fl_addr),
    .fl_dq_o(fl_dq_o),
    .fl_dq_oe_n(fl_dq_oe_n),
    .fl_ce_n(fl_ce_n),
    .fl_we_n(fl_we_n),
    .fl_oe_n(fl_oe_n),
    .rd_data(cyc_rd),
    .done(cyc_done)
  );

  // ready pin crosses in through two flops
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      rdy_m_q <= 1'b0;
      rdy_s_q <= 1'b0;
    end
    else
    begin
      rdy_m_q <= done_indicator;
      rdy_s_q <= rdy_m_q;
    end
  end

  // software-written configuration and operands
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      cfg_q <= `FH_CFG_RST;
      mask_q <= `FH_MASK_RST;
      addr_q <= '0;
      wdata_q <= 16'h0000;
    end
    else if (reg_we)
    begin
      if (reg_addr == `FH_REG_CFG)
        cfg_q <= reg_wdata[3:0];
      else if (reg_addr == `FH_REG_MASK)
        mask_q <= reg_wdata[2:0];
      else if (reg_addr == `FH_REG_ADDR)
        addr_q <= reg_wdata[AW-1:0];
      else if (reg_addr == `FH_REG_WDATA)
        wdata_q <= reg_wdata[15:0];
    end
  end

  // static pins; byte mode selects the 8-bit bus
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      fl_byte_n <= 1'b1;
      protect_accel_pin <= 1'b1;
    end
    else
    begin
      fl_byte_n <= ~cfg_q[`FH_CFG_BYTE];
      protect_accel_pin <= cfg_q[`FH_CFG_WP];
    end
  end

  // sticky events, write one to clear; a new event beats the clear
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      int_q <= 3'h0;
      irq <= 1'b0;
    end
    else
    begin
      if (reg_we && reg_addr == `FH_REG_INT)
        int_q <= (int_q & ~reg_wdata[2:0]) | {ev_ref_q, ev_tmo_q, ev_done_q};
      else
        int_q <= int_q | {ev_ref_q, ev_tmo_q, ev_done_q};
      irq <= |(int_q & mask_q);
    end
  end

  // read port: data stands the cycle after the strobe only
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      reg_rdata <= 32'h0000_0000;
    else if (!reg_re)
      reg_rdata <= 32'h0000_0000;
    else if (reg_addr == `FH_REG_CTRL)
      reg_rdata <= {28'h000_0000, op_q};
    else if (reg_addr == `FH_REG_ADDR)
      reg_rdata <= 32'(addr_q);
    else if (reg_addr == `FH_REG_WDATA)
      reg_rdata <= {16'h0000, wdata_q};
    else if (reg_addr == `FH_REG_STAT)
      reg_rdata <= {28'h000_0000, byp_q, rdy_s_q, tmo_err_q, st_q != S_IDLE};
    else if (reg_addr == `FH_REG_INT)
      reg_rdata <= {29'h0000_0000, int_q};
    else if (reg_addr == `FH_REG_MASK)
      reg_rdata <= {29'h0000_0000, mask_q};
    else if (reg_addr == `FH_REG_RDATA)
      reg_rdata <= {16'h0000, rdata_q};
    else if (reg_addr == `FH_REG_CFG)
      reg_rdata <= {28'h000_0000, cfg_q};
    else
      reg_rdata <= 32'h0000_0000;
  end

  // operation sequencer; a go while busy is dropped silently
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      st_q <= S_IDLE;
      op_q <= OP_READ;
      idx_q <= 3'h0;
      tmo_q <= 32'h0000_0000;
      tog_q <= 1'b0;
      tog_v_q <= 1'b0;
      tmo_err_q <= 1'b0;
      byp_q <= 1'b0;
      cyc_go_q <= 1'b0;
      cyc_wr_q <= 1'b0;
      ev_done_q <= 1'b0;
      ev_tmo_q <= 1'b0;
      ev_ref_q <= 1'b0;
      rdata_q <= 16'h0000;
      fl_reset_n <= 1'b0;
    end
    else
    begin
      cyc_go_q <= 1'b0;
      ev_done_q <= 1'b0;
      ev_tmo_q <= 1'b0;
      ev_ref_q <= 1'b0;
      case (st_q)
        S_IDLE:
        begin
          fl_reset_n <= 1'b1;
          if (go_req)
          begin
            op_q <= fh_op_t'(reg_wdata[3:0]);
            idx_q <= 3'h0;
            tmo_q <= 32'h0000_0000;
            tog_v_q <= 1'b0;
            tmo_err_q <= 1'b0;
            // short program only inside bypass mode
            if (fh_op_t'(reg_wdata[3:0]) == OP_BYPP && !byp_q)
              ev_ref_q <= 1'b1;
            else if (fh_op_t'(reg_wdata[3:0]) == OP_HWRS)
              st_q <= S_HWRST;
            else
              st_q <= S_ISSUE;
          end
        end
        S_ISSUE:
        begin
          cyc_go_q <= 1'b1;
          cyc_wr_q <= op_q != OP_READ;
          st_q <= S_WAITC;
        end
        S_WAITC:
          if (cyc_done)
          begin
            if (op_q == OP_READ)
            begin
              rdata_q <= cyc_rd;
              ev_done_q <= 1'b1;
              st_q <= S_IDLE;
            end
            else if (!step_last)
            begin
              idx_q <= idx_q + 3'h1;
              st_q <= S_ISSUE;
            end
            else
            begin
              if (op_q == OP_BYPE)
                byp_q <= 1'b1;
              else if (op_q == OP_BYPX || op_q == OP_RSTC)
                byp_q <= 1'b0;
              if (is_wait_op)
              begin
                tmo_q <= 32'(`FH_BUSY_CYC);
                st_q <= S_SETTLE;
              end
              else
              begin
                ev_done_q <= 1'b1;
                st_q <= S_IDLE;
              end
            end
          end
        S_SETTLE:
          // ready pin and status bits need time to turn busy
          if (tmo_q == 32'h0000_0000)
            st_q <= S_POLL;
          else
            tmo_q <= tmo_q - 32'h0000_0001;
        S_POLL:
          // completion by ready pin or status reads
          if (tmo_q == 32'(POLL_LIMIT))
          begin
            tmo_err_q <= 1'b1;
            ev_tmo_q <= 1'b1;
            st_q <= S_IDLE;
          end
          else if (cfg_q[`FH_CFG_POLL+1:`FH_CFG_POLL] == 2'b00)
          begin
            tmo_q <= tmo_q + 32'h0000_0001;
            if (rdy_s_q)
            begin
              ev_done_q <= 1'b1;
              st_q <= S_IDLE;
            end
          end
          else
          begin
            tmo_q <= tmo_q + 32'h0000_0001;
            cyc_go_q <= 1'b1;
            cyc_wr_q <= 1'b0;
            st_q <= S_POLLW;
          end
        S_POLLW:
        begin
          tmo_q <= tmo_q + 32'h0000_0001;
          if (cyc_done)
          begin
            tog_q <= cyc_rd[`FH_TOG_BIT];
            tog_v_q <= 1'b1;
            // toggle method: two equal reads mean done
            if (cfg_q[`FH_CFG_POLL] ? (tog_v_q && tog_q == cyc_rd[`FH_TOG_BIT]) : pol_ok)
            begin
              ev_done_q <= 1'b1;
              st_q <= S_IDLE;
            end
            else
              st_q <= S_POLL;
          end
        end
        S_HWRST:
        begin
          fl_reset_n <= 1'b0;
          byp_q <= 1'b0;
          if (idx_q == 3'h0)
          begin
            idx_q <= 3'h1;
            tmo_q <= 32'(`FH_RP_CYC - 1);
          end
          else if (tmo_q == 32'h0000_0000)
          begin
            fl_reset_n <= 1'b1;
            tmo_q <= 32'(`FH_RH_CYC - 1);
            st_q <= S_RECOV;
          end
          else
            tmo_q <= tmo_q - 32'h0000_0001;
        end
        default:
          if (tmo_q == 32'h0000_0000)
          begin
            ev_done_q <= 1'b1;
            st_q <= S_IDLE;
          end
          else
            tmo_q <= tmo_q - 32'h0000_0001;
      endcase
    end
  end

  // helper: write strobes since the operation began
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      wcnt_q <= 8'h00;
    else if (st_q == S_IDLE)
      wcnt_q <= 8'h00;
    else if (cyc_go_q && cyc_wr_q)
      wcnt_q <= wcnt_q + 8'h01;
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  strobe_overlap_a: assert property (!(!fl_we_n && !fl_oe_n))
    else $error("write and output strobes low together");
  we_in_ce_a: assert property (!fl_we_n |-> !fl_ce_n)
    else $error("write strobe low without chip select");
  wr_pulse_a: assert property ($fell(fl_we_n) |-> (!fl_we_n && !fl_dq_oe_n) [*7] ##1 fl_we_n)
    else $error("write pulse width or data drive wrong");
  prog_len_a: assert property (ev_done_q && op_q == OP_PROG |-> wcnt_q == 8'h04)
    else $error("program sequence not four writes");
  byp_len_a: assert property (ev_done_q && op_q == OP_BYPP |-> wcnt_q == 8'h02)
    else $error("short program not two writes");
  poll_nowr_a: assert property (st_q == S_POLL || st_q == S_POLLW |-> fl_we_n)
    else $error("write during completion polling");
  rdy_done_a: assert property (st_q == S_POLL && cfg_q[3:2] == 2'b00 && rdy_s_q
    && tmo_q != 32'(POLL_LIMIT) |=> ev_done_q && st_q == S_IDLE)
    else $error("ready pin not ending the operation");
  rst_pulse_a: assert property ($fell(fl_reset_n) && st_q == S_HWRST |-> !fl_reset_n [*8])
    else $error("reset pulse too short");
  prog_c: cover property (ev_done_q && op_q == OP_PROG);
  byp_c: cover property (ev_done_q && op_q == OP_BYPP);
  tmo_c: cover property (ev_tmo_q);
  tog_c: cover property (ev_done_q && op_q == OP_SERS && cfg_q[3:2] == 2'b01);
endmodule : fh_host

// file: bench/fh_flash_model.sv
// behavioural parallel nor flash seen at its pins
`timescale 1ns/1ps
module fh_flash_model #(
  parameter int AW = 26,
  parameter int SB = 8
)(
  input wire logic [AW-1:0] fl_addr,
  input wire logic [15:0] fl_dq_o,
  input wire logic fl_ce_n,
  input wire logic fl_we_n,
  input wire logic fl_oe_n,
  input wire logic fl_byte_n,
  input wire logic fl_reset_n,
  input wire logic protect_accel_pin,
  input wire logic stall,
  output logic [15:0] fl_dq_i,
  output logic done_indicator
);
  logic [15:0] mem [int];
  logic [15:0] rd_v = 0;
  logic [15:0] last_q = 0;
  logic tog_q = 0;
  logic pol_q = 0;
  logic byp_q = 0;
  logic ers_q = 0;
  int st_q = 0;
  int bsy_q = 0;
  int a;
  logic [7:0] d;
  function automatic logic [15:0] rdm(int x);
    return mem.exists(x) ? mem[x] : 16'hFFFF;
  endfunction : rdm
  // command decode on write strobe rise
  always @(posedge fl_we_n)
    if (!fl_ce_n && fl_reset_n)
    begin
      a = fl_byte_n ? fl_addr : fl_addr >> 1;
      d = fl_dq_o[7:0];
      if (st_q == 3)
      begin
        st_q = 0;
        if (protect_accel_pin || (a >> SB) != 0)
        begin
          mem[a] = rdm(a) & fl_dq_o;
          pol_q = ~fl_dq_o[7];
          bsy_q = 60;
        end
      end
      else if (byp_q && st_q == 0 && d == 8'hA0) st_q = 3;
      else if (byp_q && st_q == 0 && d == 8'h90) st_q = 5;
      else if (st_q == 5)
      begin
        byp_q = 0;
        st_q = 0;
      end
      else if (d == 8'hF0) st_q = 0;
      else if (st_q == 0) st_q = (a == 'h555 && d == 8'hAA) ? 1 : 0;
      else if (st_q == 1) st_q = (a == 'h2AA && d == 8'h55) ? 2 : 0;
      else
      begin
        st_q = (d == 8'hA0) ? 3 : 0;
        byp_q = byp_q | (d == 8'h20);
        if (ers_q && d == 8'h30)
          for (int k = 0; k < (1 << SB); k++)
            if (mem.exists(((a >> SB) << SB) + k)) mem.delete(((a >> SB) << SB) + k);
        if (ers_q && d == 8'h10) mem.delete();
        if (ers_q && (d == 8'h30 || d == 8'h10))
        begin
          pol_q = 0;
          bsy_q = 120;
        end
        ers_q = (d == 8'h80);
      end
    end
  // reset pin aborts; timer frozen while stalled to force a hang
  always #5
    if (!fl_reset_n)
    begin
      bsy_q = 0;
      st_q = 0;
      byp_q = 0;
      ers_q = 0;
    end
    else if (bsy_q > 0 && !stall) bsy_q--;
  // toggle bit flips on every read while busy
  always @(negedge fl_oe_n)
    if (bsy_q > 0) tog_q = ~tog_q;
  // read path, byte lane by lowest address bit
  always @(fl_addr, fl_byte_n, fl_oe_n, bsy_q, tog_q, pol_q)
  begin
    rd_v = rdm(fl_byte_n ? fl_addr : fl_addr >> 1);
    if (!fl_byte_n) rd_v = fl_addr[0] ? rd_v >> 8 : rd_v & 16'h00FF;
    if (bsy_q > 0) rd_v = {8'h00, pol_q, tog_q, 6'h00};
  end
  // ready pin; a released bus shows the inverse of the last value
  assign done_indicator = fl_reset_n && bsy_q == 0;
  assign fl_dq_i = (!fl_ce_n && !fl_oe_n) ? rd_v : ~last_q;
  always @(fl_dq_i)
    if (!fl_ce_n && !fl_oe_n) last_q = rd_v;
endmodule : fh_flash_model

// file: bench/fh_host_tb.sv
// self-checking bench of the nor flash host controller
`timescale 1ns/1ps
`include "fh_cfg.svh"
module fh_host_tb;
  logic clk_sys = 0;
  logic nrst = 0;
  logic [7:0] reg_addr = 0;
  logic [31:0] reg_wdata = 0;
  logic reg_we = 0;
  logic reg_re = 0;
  logic stall = 0;
  logic [31:0] reg_rdata, rv;
  logic irq, oe_dq_n, ce_n, we_n, oe_n, byte_n, rst_n, wp, rdy;
  logic [25:0] fl_addr;
  logic [15:0] dq_i, dq_o, d;
  int err_count = 0, total_checks = 0, cyc = 0, rlow = 0, rlen = 0, cfg = 2;
  logic [15:0] mem [int];
  always #2.5 clk_sys = ~clk_sys;
  fh_host #(.AW(26), .POLL_LIMIT(2000)) dut (.clk_sys(clk_sys), .nrst(nrst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
    .reg_rdata(reg_rdata), .irq(irq), .fl_addr(fl_addr), .fl_dq_i(dq_i), .fl_dq_o(dq_o),
    .fl_dq_oe_n(oe_dq_n), .fl_ce_n(ce_n), .fl_we_n(we_n), .fl_oe_n(oe_n),
    .fl_byte_n(byte_n), .fl_reset_n(rst_n), .protect_accel_pin(wp), .done_indicator(rdy));
  fh_flash_model #(.AW(26), .SB(8)) flash (.fl_addr(fl_addr), .fl_dq_o(dq_o),
    .fl_ce_n(ce_n), .fl_we_n(we_n), .fl_oe_n(oe_n), .fl_byte_n(byte_n),
    .fl_reset_n(rst_n), .protect_accel_pin(wp), .stall(stall), .fl_dq_i(dq_i),
    .done_indicator(rdy));
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : complete_run
  // run guard and length of the last flash reset pulse
  always @(posedge clk_sys)
  begin
    cyc++;
    rlow = rst_n ? 0 : rlow + 1;
    if (rlow > 0) rlen = rlow;
    if (cyc == 90000)
    begin
      err_count++;
      complete_run();
    end
  end
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(logic [7:0] a, logic [31:0] v);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= v;
    reg_we <= 1;
    @(posedge clk_sys);
    reg_we <= 0;
  endtask : wr
  task automatic rd(logic [7:0] a, output logic [31:0] v);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_re <= 1;
    @(posedge clk_sys);
    reg_re <= 0;
    #1 v = reg_rdata;
  endtask : rd
  // clears events, starts an op, waits for any event bit
  task automatic op(int o, int a, int v, output logic [31:0] st);
    int n;
    n = 0;
    wr(`FH_REG_INT, 32'h0000_0007);
    wr(`FH_REG_ADDR, a);
    wr(`FH_REG_WDATA, v);
    wr(`FH_REG_CTRL, 32'h0000_0010 | o);
    st = 0;
    while (st[2:0] == 0 && n < 20000)
    begin
      rd(`FH_REG_INT, st);
      n++;
    end
    // a wait of 20000 reads with no event bit counts as a mismatch
    chk("op event", 1, st[2:0] != 0);
  endtask : op
  function automatic logic [15:0] ex(int a);
    return mem.exists(a) ? mem[a] : 16'hFFFF;
  endfunction : ex
  task automatic prog(int o, int a, logic [15:0] v);
    op(o, a, v, rv);
    chk("program done", 1, rv[0]);
    if (cfg[1] || a >= 256) mem[a] = ex(a) & v;
  endtask : prog
  task automatic cmp_rd(int a);
    op(0, a, 0, rv);
    rd(`FH_REG_RDATA, rv);
    chk("read data", ex(a), rv[15:0]);
  endtask : cmp_rd
  task automatic irq_is(logic [7:0] a, logic [31:0] v, logic e);
    wr(a, v);
    repeat (2) @(posedge clk_sys);
    chk("irq", e, irq);
  endtask : irq_is
  initial
  begin
    d = 16'($urandom(32'h7de9));
    repeat (20) @(posedge clk_sys);
    nrst <= 1;
    rd(`FH_REG_CFG, rv);
    chk("cfg reset", 2, rv[3:0]);
    rd(`FH_REG_MASK, rv);
    chk("mask reset", 0, rv[2:0]);
    rd(8'h40, rv);
    chk("unmapped", 0, rv);
    chk("flash reset released", 1, rst_n);
    $display("test reset done");
    // poll select 11 decodes as toggle polling
    for (int pm = 0; pm < 4; pm++)
    begin
      cfg = 2 | (pm << 2);
      wr(`FH_REG_CFG, cfg);
      prog(1, 320 + pm, 16'($urandom));
      cmp_rd(320 + pm);
    end
    cfg = 2;
    wr(`FH_REG_CFG, cfg);
    prog(1, 320, 16'($urandom));
    cmp_rd(320);
    $display("test poll modes done");
    op(4, 0, 0, rv);
    rd(`FH_REG_STAT, rv);
    chk("bypass on", 1, rv[3]);
    prog(5, 330, 16'($urandom));
    cmp_rd(330);
    op(6, 0, 0, rv);
    rd(`FH_REG_STAT, rv);
    chk("bypass off", 0, rv[3]);
    wr(`FH_REG_MASK, 4);
    op(5, 331, 0, rv);
    chk("short refused", 1, rv[2]);
    // irq checks first: the read op below clears the refused bit
    irq_is(`FH_REG_MASK, 4, 1);
    irq_is(`FH_REG_MASK, 0, 0);
    irq_is(`FH_REG_MASK, 4, 1);
    irq_is(`FH_REG_INT, 4, 0);
    cmp_rd(331);
    $display("test bypass done");
    d = 16'($urandom);
    prog(1, 512, d);
    op(2, 330, 0, rv);
    for (int k = 256; k < 512; k++)
      if (mem.exists(k)) mem.delete(k);
    cmp_rd(320);
    cmp_rd(512);
    cfg = 0;
    wr(`FH_REG_CFG, cfg);
    // pin follows the config register one cycle later
    @(posedge clk_sys);
    #1 chk("wp pin low", 0, wp);
    prog(1, 5, 16'h0000);
    cmp_rd(5);
    wr(`FH_REG_CFG, 3);
    @(posedge clk_sys);
    #1 chk("byte select", 0, byte_n);
    for (int b = 0; b < 2; b++)
    begin
      op(0, 1024 + b, 0, rv);
      rd(`FH_REG_RDATA, rv);
      chk("byte lane", (d >> (8 * b)) & 8'hFF, rv[7:0]);
    end
    cfg = 2;
    wr(`FH_REG_CFG, cfg);
    $display("test erase protect byte done");
    for (int o = 7; o < 12; o++)
    begin
      op(o, 0, 0, rv);
      chk("suspend resume op", 1, rv[0]);
    end
    d = 16'($urandom);
    @(posedge clk_sys) stall <= 1;
    op(1, 333, d, rv);
    chk("poll timeout", 1, rv[1]);
    mem[333] = d;
    @(posedge clk_sys) stall <= 0;
    op(12, 0, 0, rv);
    chk("reset pulse", `FH_RP_CYC, rlen);
    rd(`FH_REG_STAT, rv);
    chk("ready after reset", 1, rv[2]);
    cmp_rd(333);
    op(3, 0, 0, rv);
    mem.delete();
    cmp_rd(512);
    $display("test timeout reset chip erase done");
    complete_run();
  end
endmodule : fh_host_tb
